// [design/lafe_pkg.sv]
// constants for the long-address legacy receive frame emitter
// assumes one 100 MHz clock domain and a byte-wide output stream
package lafe_pkg;

    // frame bytes
    localparam logic [7:0]  START_DELIM    = 8'h7e;
    localparam logic [7:0]  FRAME_TYPE     = 8'h80;
    localparam logic [7:0]  CSUM_BASE      = 8'hff;

    // frame is emitted only for this output format and sender setting
    localparam logic [7:0]  FMT_LEGACY     = 8'h02;
    localparam logic [15:0] LONG_ADDR_MARK = 16'hfffe;

    // receive option flags (bit 0 reserved, passed through as given)
    localparam logic [7:0]  OPT_BCAST      = 8'h02;
    localparam logic [7:0]  OPT_ALL_PANS   = 8'h04;

    // frame offsets
    localparam logic [15:0] OFF_DELIM      = 16'h0000;
    localparam logic [15:0] OFF_LEN_HI     = 16'h0001;
    localparam logic [15:0] OFF_LEN_LO     = 16'h0002;
    localparam logic [15:0] OFF_TYPE       = 16'h0003;
    localparam logic [15:0] OFF_ADDR       = 16'h0004;
    localparam logic [15:0] OFF_RSSI       = 16'h000c;
    localparam logic [15:0] OFF_OPTS       = 16'h000d;
    localparam logic [15:0] OFF_DATA       = 16'h000e;

    // length field counts type, address, rssi and options plus payload
    localparam logic [15:0] FIXED_LEN      = 16'h000b;
    localparam logic [2:0]  ADDR_LAST_IDX  = 3'h7;

    // payload buffer
    localparam int          FIFO_WIDTH     = 8;
    localparam int          FIFO_DEPTH     = 32;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_DELIM  = 4'h1,
        ST_LEN_HI = 4'h3,
        ST_LEN_LO = 4'h2,
        ST_TYPE   = 4'h6,
        ST_ADDR   = 4'h7,
        ST_RSSI   = 4'h5,
        ST_OPTS   = 4'h4,
        ST_DATA   = 4'hc,
        ST_CSUM   = 4'hd,
        ST_DROP   = 4'h8
    } lafe_state_type;

    // running 8-bit checksum sum, carries dropped
    function automatic logic [7:0] lafe_csum_add(input logic [7:0] sum,
                                                 input logic [7:0] b);
        lafe_csum_add = sum + b;
    endfunction

endpackage

// [design/lafe_emitter.sv]
// payload buffer and frame emitter for long-address legacy receive frames
// assumes the radio side presents one header per packet, then its payload
// bytes, and that the host drains the byte stream with out_ready
`timescale 1ns/1ps

module lafe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] NEAR_FULL = (AW+1)'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             full_q;
    logic             push;
    logic             pop;

    // full lives in its own flop so in_ready comes straight from a register
    assign in_ready  = !full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
                full_q <= (cnt_q == NEAR_FULL);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
                full_q <= 1'b0;
            end
        end
    end
endmodule

// Notes on behaviour
// - emit only when format is 2 and sender short address is 0xfffe
// - byte 0 of every frame is the start delimiter
// - bytes 1-2 give the count of bytes between length and checksum
// - byte 3 carries frame type 0x80
// - bytes 4-11 carry the sender's 64-bit address
// - byte 12 is signal strength magnitude in dBm
// - byte 13 is options: 0x02 broadcast, 0x04 all PANs, combinable
// - payload bytes follow in order from byte 14 up to the checksum
// - checksum is 0xff minus 8-bit sum from byte 3 to last payload
module lafe_emitter
    import lafe_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  output_format_select,
    input  wire logic        hdr_valid,
    output      logic        hdr_ready,
    input  wire logic [15:0] hdr_sender_short_addr,
    input  wire logic [63:0] hdr_src_addr,
    input  wire logic [7:0]  hdr_rssi,
    input  wire logic [7:0]  hdr_options,
    input  wire logic [15:0] hdr_payload_len,
    input  wire logic        pay_valid,
    output      logic        pay_ready,
    input  wire logic [7:0]  pay_data,
    output      logic        out_valid,
    input  wire logic        out_ready,
    output      logic [7:0]  out_data,
    output      logic        out_last,
    output      logic        frame_dropped
);
    import lafe_pkg::*;

    lafe_state_type state_q;
    lafe_state_type state_d;
    logic [63:0]    src_q;
    logic [7:0]     rssi_q;
    logic [7:0]     opts_q;
    logic [15:0]    plen_q;
    logic [15:0]    len_q;
    logic [15:0]    cnt_q;
    logic [15:0]    cnt_d;
    logic [7:0]     sum_q;
    logic [7:0]     sum_d;
    logic           hdr_ready_q;
    logic           out_valid_q;
    logic [7:0]     out_data_q;
    logic           out_last_q;
    logic           dropped_q;
    logic           take;
    logic           match;
    logic           adv;
    logic           load;
    logic [7:0]     byte_d;
    logic           last_d;
    logic           fifo_valid;
    logic           fifo_pop;
    logic [7:0]     fifo_data;

    assign hdr_ready     = hdr_ready_q;
    assign out_valid     = out_valid_q;
    assign out_data      = out_data_q;
    assign out_last      = out_last_q;
    assign frame_dropped = dropped_q;

    lafe_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (pay_valid),
        .in_ready  (pay_ready),
        .in_data   (pay_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign take  = hdr_valid && hdr_ready_q;
    assign match = (output_format_select == FMT_LEGACY) &&
                   (hdr_sender_short_addr == LONG_ADDR_MARK);
    // a held byte may be replaced in the cycle the host takes it
    assign adv   = !out_valid_q || out_ready;

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        sum_d    = sum_q;
        load     = 1'b0;
        byte_d   = out_data_q;
        last_d   = 1'b0;
        fifo_pop = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    cnt_d = hdr_payload_len;
                    if (match) begin
                        state_d = ST_DELIM;
                    end else if (hdr_payload_len != '0) begin
                        state_d = ST_DROP;
                    end
                end
            end
            ST_DELIM: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = START_DELIM;
                    state_d = ST_LEN_HI;
                end
            end
            ST_LEN_HI: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = len_q[15:8];
                    state_d = ST_LEN_LO;
                end
            end
            ST_LEN_LO: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = len_q[7:0];
                    sum_d   = '0;
                    state_d = ST_TYPE;
                end
            end
            ST_TYPE: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = FRAME_TYPE;
                    cnt_d   = '0;
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (adv) begin
                    load   = 1'b1;
                    byte_d = src_q[{~cnt_q[2:0], 3'h0} +: 8];
                    cnt_d  = cnt_q + 16'h0001;
                    if (cnt_q[2:0] == ADDR_LAST_IDX) begin
                        state_d = ST_RSSI;
                    end
                end
            end
            ST_RSSI: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = rssi_q;
                    state_d = ST_OPTS;
                end
            end
            ST_OPTS: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = opts_q;
                    cnt_d   = plen_q;
                    state_d = (plen_q == '0) ? ST_CSUM : ST_DATA;
                end
            end
            ST_DATA: begin
                if (adv && fifo_valid) begin
                    load     = 1'b1;
                    byte_d   = fifo_data;
                    fifo_pop = 1'b1;
                    cnt_d    = cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        state_d = ST_CSUM;
                    end
                end
            end
            ST_CSUM: begin
                if (adv) begin
                    load    = 1'b1;
                    byte_d  = CSUM_BASE - sum_q;
                    last_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_DROP: begin
                // unmatched packets still drain their payload
                if (fifo_valid) begin
                    fifo_pop = 1'b1;
                    cnt_d    = cnt_q - 16'h0001;
                    if (cnt_q == 16'h0001) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (load && (state_q inside {ST_TYPE, ST_ADDR, ST_RSSI,
                                     ST_OPTS, ST_DATA})) begin
            sum_d = lafe_csum_add(sum_q, byte_d);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            sum_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sum_q   <= sum_d;
        end
    end

    // header fields are held for the whole frame
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            src_q  <= '0;
            rssi_q <= '0;
            opts_q <= '0;
            plen_q <= '0;
            len_q  <= '0;
        end else if (take) begin
            src_q  <= hdr_src_addr;
            rssi_q <= hdr_rssi;
            opts_q <= hdr_options;
            plen_q <= hdr_payload_len;
            len_q  <= FIXED_LEN + hdr_payload_len;
        end
    end

    // header taken only once idle and the checksum has left
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hdr_ready_q <= 1'b0;
        end else begin
            hdr_ready_q <= (state_q == ST_IDLE) && !out_valid_q && !take;
        end
    end

    // byte strobe held until the host accepts it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
            out_last_q  <= 1'b0;
        end else if (load) begin
            out_valid_q <= 1'b1;
            out_data_q  <= byte_d;
            out_last_q  <= last_d;
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
            out_last_q  <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dropped_q <= 1'b0;
        end else begin
            dropped_q <= take && !match;
        end
    end

    // checker helpers: offset, length and sum of bytes the host has taken
    logic [15:0] chk_off_q;
    logic [15:0] chk_len_q;
    logic [7:0]  chk_sum_q;
    logic        acc;

    assign acc = out_valid_q && out_ready;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            chk_off_q <= '0;
            chk_len_q <= '0;
            chk_sum_q <= '0;
        end else if (acc) begin
            chk_off_q <= out_last_q ? '0 : chk_off_q + 16'h0001;
            if (chk_off_q == OFF_LEN_HI) begin
                chk_len_q[15:8] <= out_data_q;
            end
            if (chk_off_q == OFF_LEN_LO) begin
                chk_len_q[7:0] <= out_data_q;
            end
            if (out_last_q) begin
                chk_sum_q <= '0;
            end else if (chk_off_q >= OFF_TYPE) begin
                chk_sum_q <= lafe_csum_add(chk_sum_q, out_data_q);
            end
        end
    end

    a_unmatched_silent: assert property (
        @(posedge clock) disable iff (reset)
        take && !match |=> !out_valid_q && dropped_q)
        else $error("unmatched packet produced output");

    a_delim_first: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && chk_off_q == OFF_DELIM |-> out_data_q == START_DELIM)
        else $error("first byte is not the delimiter");

    a_length_total: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && out_last_q |-> chk_off_q == chk_len_q + OFF_TYPE)
        else $error("length field disagrees with frame size");

    a_type_code: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && chk_off_q == OFF_TYPE |-> out_data_q == FRAME_TYPE)
        else $error("wrong frame type byte");

    a_addr_msb: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && chk_off_q == OFF_ADDR |-> out_data_q == src_q[63:56])
        else $error("address not sent top byte first");

    a_rssi_byte: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && chk_off_q == OFF_RSSI |-> out_data_q == rssi_q)
        else $error("rssi byte misplaced");

    a_opts_byte: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && chk_off_q == OFF_OPTS |-> out_data_q == opts_q)
        else $error("options byte misplaced");

    a_checksum: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && out_last_q |-> out_data_q == CSUM_BASE - chk_sum_q)
        else $error("checksum byte wrong");

    a_byte_held: assert property (
        @(posedge clock) disable iff (reset)
        out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
        else $error("byte changed before the host took it");

    a_no_overlap: assert property (
        @(posedge clock) disable iff (reset)
        hdr_ready_q |-> !out_valid_q && state_q == ST_IDLE)
        else $error("header accepted while a frame is in flight");
endmodule

// [test/lafe_host_model.sv]
// host side model: drains the emitter byte stream and records whole frames
// assumes bytes are offered with out_valid and the frame ends on out_last
`timescale 1ns/1ps

module lafe_host_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       stall,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output      logic       out_ready
);
    logic [7:0] cur[$];
    logic [7:0] last_frame[$];
    logic [1:0] tick_q;
    logic [7:0] sum;
    int         frames_done = 0;
    int         csum_bad    = 0;

    // a stalling host takes one byte in four, so the emitter must hold
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            tick_q    <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            tick_q    <= tick_q + 2'h1;
            out_ready <= !stall || (tick_q == 2'h3);
        end
    end

    // legacy frames read here for compatibility only
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            cur.delete();
        end else if (out_valid && out_ready) begin
            cur.push_back(out_data);
            if (out_last) begin
                sum = 8'h00;
                for (int i = 3; i < cur.size() - 1; i++) sum += cur[i];
                // host verifies checksum
                if ((8'hff - sum) !== cur[cur.size() - 1]) csum_bad++;
                last_frame = cur;
                cur.delete();
                frames_done++;
            end
        end
    end
endmodule

// [test/lafe_emitter_tb.sv]
// self-checking bench for the long-address legacy receive frame emitter
// assumes the host model drains output bytes and records whole frames
`timescale 1ns/1ps

module lafe_emitter_tb;
    import lafe_pkg::*;
    // sender address value is arbitrary
    localparam logic [63:0] TEST_ADDR = 64'h0123456789abcdef;
    localparam int          LIMIT     = 20000;

    logic        clock;
    logic        reset;
    logic        stall;
    logic [7:0]  output_format_select;
    logic        hdr_valid;
    logic        hdr_ready;
    logic [15:0] hdr_sender_short_addr;
    logic [63:0] hdr_src_addr;
    logic [7:0]  hdr_rssi;
    logic [7:0]  hdr_options;
    logic [15:0] hdr_payload_len;
    logic        pay_valid;
    logic        pay_ready;
    logic [7:0]  pay_data;
    logic        out_valid;
    logic        out_ready;
    logic [7:0]  out_data;
    logic        out_last;
    logic        frame_dropped;
    int          fail_count;
    int          compares;
    int          cycles;

    lafe_emitter u_lafe_emitter (
        .clock(clock), .reset(reset),
        .output_format_select(output_format_select),
        .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_sender_short_addr(hdr_sender_short_addr),
        .hdr_src_addr(hdr_src_addr), .hdr_rssi(hdr_rssi),
        .hdr_options(hdr_options), .hdr_payload_len(hdr_payload_len),
        .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_last(out_last), .frame_dropped(frame_dropped)
    );

    lafe_host_model u_lafe_host_model (
        .clock(clock), .reset(reset), .stall(stall),
        .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready)
    );

    always #5 clock = ~clock;

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    // entered just after a rising edge; returns at the edge that took it
    task automatic push(input logic [7:0] b);
        pay_valid <= 1'b1;
        pay_data  <= b;
        @(negedge clock);
        for (int k = 0; k < 200 && pay_ready !== 1'b1; k++) @(negedge clock);
        @(posedge clock);
    endtask

    task automatic send_pkt(input logic [7:0] fmt, input logic [15:0] sa,
                            input logic [7:0] rssi, input logic [7:0] opts,
                            input int len, input logic [7:0] base,
                            input bit pre);
        logic [7:0] got[$];
        logic [7:0] sum;
        logic [63:0] addr;
        int n;
        int drops;
        bit match;
        match = (fmt == 8'h02) && (sa == 16'hfffe);
        drops = 0;
        if (!pre) begin
            @(posedge clock);
            for (int i = 0; i < len; i++) push(base + 8'(i));
            pay_valid <= 1'b0;
        end
        @(posedge clock);
        output_format_select  <= fmt;
        hdr_sender_short_addr <= sa;
        hdr_src_addr          <= TEST_ADDR;
        hdr_rssi              <= rssi;
        hdr_options           <= opts;
        hdr_payload_len       <= 16'(len);
        hdr_valid             <= 1'b1;
        n = u_lafe_host_model.frames_done;
        @(negedge clock);
        for (int k = 0; k < 200 && hdr_ready !== 1'b1; k++) @(negedge clock);
        @(posedge clock);
        hdr_valid <= 1'b0;
        for (int k = 0; k < (match ? 600 : 30)
             && u_lafe_host_model.frames_done == n; k++) begin
            @(negedge clock);
            if (frame_dropped === 1'b1) drops++;
            if (out_valid === 1'b1) check("hdr_ready", hdr_ready, 1'b0);
        end
        check("frames", 64'(u_lafe_host_model.frames_done - n), 64'(match));
        check("drops", 64'(drops), 64'(!match));
        if (match) begin
            got = u_lafe_host_model.last_frame;
            sum = 8'h80 + rssi + opts;
            for (int i = 0; i < 8; i++) begin
                addr[63 - 8 * i -: 8] = got[4 + i];
                sum += TEST_ADDR[63 - 8 * i -: 8];
            end
            check("size", 64'(got.size()), 64'(15 + len));
            check("delim", got[0], 8'h7e);
            check("length", {got[1], got[2]}, 64'(11 + len));
            check("type", got[3], 8'h80);
            check("address", addr, TEST_ADDR);
            check("rssi", got[12], rssi);
            check("options", got[13], opts);
            for (int i = 0; i < len; i++) begin
                sum += base + 8'(i);
                check("payload", got[14 + i], base + 8'(i));
            end
            check("checksum", got[got.size() - 1], 8'hff - sum);
        end
    endtask

    task automatic test_basic();
        send_pkt(8'h02, 16'hfffe, 8'h5e, 8'h01, 6, 8'h54, 1'b0);
    endtask

    // mismatched packets must be dropped and their payload discarded
    task automatic test_drop();
        send_pkt(8'h01, 16'hfffe, 8'h28, 8'h00, 3, 8'h10, 1'b0);
        send_pkt(8'h02, 16'hffff, 8'h28, 8'h00, 2, 8'h20, 1'b0);
        send_pkt(8'h02, 16'h1234, 8'h28, 8'h02, 1, 8'h21, 1'b0);
        // an empty unmatched packet has nothing to drain
        send_pkt(8'h02, 16'h0001, 8'h28, 8'h00, 0, 8'h00, 1'b0);
    endtask

    task automatic test_options();
        logic [7:0] opt_tab[4] = '{8'h02, 8'h04, 8'h06, 8'h01};
        int len_tab[4] = '{0, 1, 0, 2};
        for (int t = 0; t < 4; t++) begin
            @(posedge clock);
            stall <= t[0];
            send_pkt(8'h02, 16'hfffe, 8'h28, opt_tab[t], len_tab[t],
                     8'h30, 1'b0);
        end
        @(posedge clock);
        stall <= 1'b0;
    endtask

    task automatic test_full();
        @(posedge clock);
        for (int i = 0; i < FIFO_DEPTH; i++) push(8'h40 + 8'(i));
        pay_data <= 8'hee;
        repeat (3) @(negedge clock);
        check("full refuses", pay_ready, 1'b0);
        @(posedge clock);
        pay_valid <= 1'b0;
        stall     <= 1'b1;
        send_pkt(8'h02, 16'hfffe, 8'h7f, 8'h06, FIFO_DEPTH, 8'h40, 1'b1);
        @(posedge clock);
        stall <= 1'b0;
    endtask

    initial begin
        clock = 1'b0;
        reset = 1'b1;
        stall = 1'b0;
        output_format_select = 8'h00;
        hdr_valid = 1'b0;
        hdr_sender_short_addr = 16'h0000;
        hdr_src_addr = 64'h0;
        hdr_rssi = 8'h00;
        hdr_options = 8'h00;
        hdr_payload_len = 16'h0000;
        pay_valid = 1'b0;
        pay_data = 8'h00;
        fail_count = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        test_basic();
        test_drop();
        test_options();
        test_full();
        check("host checksum", 64'(u_lafe_host_model.csum_bad), 64'h0);
        summarize();
    end
endmodule
